// ==== common/scp_pkg.sv ====
// Shared constants and types for the serial command line parser.
package scp_pkg;

  // Control characters that steer the line editor and command state.
  localparam logic [7:0] CH_PREFIX = 8'h02;
  localparam logic [7:0] CH_SUFFIX = 8'h03;
  localparam logic [7:0] CH_BS     = 8'h08;
  localparam logic [7:0] CH_TAB    = 8'h09;
  localparam logic [7:0] CH_LF     = 8'h0a;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_ESC    = 8'h1b;

  // Printable characters with a syntactic meaning.
  localparam logic [7:0] CH_SPACE  = 8'h20;
  localparam logic [7:0] CH_QUOTE  = 8'h22;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_COMMA  = 8'h2c;
  localparam logic [7:0] CH_SEMI   = 8'h3b;
  localparam logic [7:0] CH_BSL    = 8'h5c;
  localparam logic [7:0] CH_DIG0   = 8'h30;
  localparam logic [7:0] CH_DIG9   = 8'h39;
  localparam logic [7:0] CH_UP_A   = 8'h41;
  localparam logic [7:0] CH_UP_F   = 8'h46;
  localparam logic [7:0] CH_UP_Z   = 8'h5a;
  localparam logic [7:0] CH_LO_A   = 8'h61;
  localparam logic [7:0] CH_LO_Z   = 8'h7a;
  localparam logic [7:0] CASE_DIFF = 8'h20;
  localparam logic [7:0] HEX_AOFS  = 8'h37;

  // Escape letters inside strings and the codes they stand for.
  localparam logic [7:0] ESC_A = 8'h61;
  localparam logic [7:0] ESC_B = 8'h62;
  localparam logic [7:0] ESC_F = 8'h66;
  localparam logic [7:0] ESC_N = 8'h6e;
  localparam logic [7:0] ESC_R = 8'h72;
  localparam logic [7:0] ESC_T = 8'h74;
  localparam logic [7:0] ESC_V = 8'h76;
  localparam logic [7:0] CH_BEL = 8'h07;
  localparam logic [7:0] CH_FF  = 8'h0c;
  localparam logic [7:0] CH_VT  = 8'h0b;

  // Line buffer size and numeric bases.
  localparam int         LINE_MAX     = 80;
  localparam logic [6:0] LINE_MAX_CNT = 7'h50;
  localparam logic [15:0] BASE_DEC    = 16'h000a;
  localparam logic [15:0] BASE_HEX    = 16'h0010;

  // Configuration memory layout and the write command name.
  localparam logic [15:0] CFG_PTR_HI   = 16'h0000;
  localparam logic [15:0] CFG_PTR_LO   = 16'h0001;
  localparam logic [15:0] CFG_CMD_NAME = 16'h4545;

  // Main controller states.
  typedef enum logic [10:0] {
    ST_IDLE     = 11'h001,
    ST_PARSE    = 11'h002,
    ST_RD_HI    = 11'h004,
    ST_RD_LO    = 11'h008,
    ST_CAP_HI   = 11'h010,
    ST_CAP_LO   = 11'h020,
    ST_WAIT_LEN = 11'h040,
    ST_CAP_LEN  = 11'h080,
    ST_RD_CHR   = 11'h100,
    ST_WAIT_CHR = 11'h200,
    ST_FEED     = 11'h400
  } scp_state_e;

  // Token being assembled.
  typedef enum logic [3:0] {
    TK_NONE = 4'h1,
    TK_DEC  = 4'h2,
    TK_HEX  = 4'h4,
    TK_NAME = 4'h8
  } scp_tok_e;

  // What the current line turned out to be.
  typedef enum logic [3:0] {
    LK_NONE = 4'h1,
    LK_CMD  = 4'h2,
    LK_CFG  = 4'h4,
    LK_DATA = 4'h8
  } scp_line_e;

  // Element kinds handed to the command executor.
  typedef enum logic [2:0] {
    EK_NAME = 3'h1,
    EK_NUM  = 3'h2,
    EK_CHAR = 3'h4
  } scp_kind_e;

  typedef struct packed {
    logic        first;
    scp_kind_e   kind;
    logic [15:0] data;
  } scp_elem_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } scp_cfg_s;

endpackage : scp_pkg

// ==== hdl/scp_line_buf.sv ====
// Editable line buffer holding one command line of at most eighty bytes.
`timescale 1ns/1ps
`default_nettype none

module scp_line_buf (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Edit controls.
  input  wire logic       clr_i,
  input  wire logic       pop_i,
  input  wire logic       push_i,
  input  wire logic [7:0] data_i,
  // Read side.
  input  wire logic [6:0] idx_i,
  output logic      [6:0] cnt_o,
  output logic      [7:0] rd_o
);

  typedef struct packed {
    logic [scp_pkg::LINE_MAX-1:0][7:0] mem;
    logic [6:0]                        cnt;
  } scp_lb_s;

  scp_lb_s r_reg;
  scp_lb_s r_next;

  // Clear wins over delete, delete over append.
  always_comb begin
    r_next = r_reg;
    if (clr_i) begin
      r_next.cnt = '0;
    end else if (pop_i) begin
      if (r_reg.cnt != '0) begin
        r_next.cnt = r_reg.cnt - 7'h01;
      end
    end else if (push_i && r_reg.cnt < scp_pkg::LINE_MAX_CNT) begin
      // A full line drops further bytes rather than wrapping.
      r_next.mem[r_reg.cnt] = data_i;
      r_next.cnt            = r_reg.cnt + 7'h01;
    end
    if (rst_i) begin
      r_next.cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    r_reg <= r_next;
  end

  // Reads past the fill level return zero so no stale byte leaks out.
  assign cnt_o = r_reg.cnt;
  assign rd_o  = (idx_i < r_reg.cnt) ? r_reg.mem[idx_i] : 8'h00;

endmodule : scp_line_buf

`default_nettype wire

// ==== hdl/scp_parser.sv ====
// Serial command line parser: editing, tokenising, config writes, replay.
`timescale 1ns/1ps
`default_nettype none

module scp_parser (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Character stream from the host.
  input  wire logic              in_valid_i,
  input  wire logic [7:0]        in_char_i,
  output logic                   in_ready_o,
  // Configuration memory port, read data one cycle after the request.
  output logic                   cfg_rd_o,
  output logic                   cfg_wr_o,
  output logic [15:0]            cfg_addr_o,
  output logic [7:0]             cfg_wdata_o,
  input  wire logic [7:0]        cfg_rdata_i,
  // Parsed elements and execute strobe.
  output logic                   cmd_state_o,
  output logic                   elem_valid_o,
  output scp_pkg::scp_elem_s     elem_o,
  output logic                   exec_o
);

  typedef struct packed {
    scp_pkg::scp_state_e st;
    logic                cmd_state;
    logic                replay;
    logic                prev_cr;
    logic [7:0]          rem;
    logic [15:0]         ptr;
    logic [6:0]          idx;
    scp_pkg::scp_tok_e   tok;
    logic [15:0]         acc;
    logic                in_str;
    logic                esc;
    logic                cmt;
    scp_pkg::scp_line_e  lk;
    logic                addr_seen;
    logic [15:0]         wpos;
    logic                wpos_ok;
    logic                ready;
    logic                elem_valid;
    scp_pkg::scp_elem_s  elem;
    logic                exec;
    scp_pkg::scp_cfg_s   cfg;
  } scp_core_s;

  scp_core_s r_reg;
  scp_core_s r_next;

  logic       lb_clr;
  logic       lb_pop;
  logic       lb_push;
  logic [7:0] lb_rd;
  logic [6:0] lb_cnt;
  logic [7:0] ch;

  function automatic logic is_digit(input logic [7:0] c);
    return c >= scp_pkg::CH_DIG0 && c <= scp_pkg::CH_DIG9;
  endfunction : is_digit

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    if (c >= scp_pkg::CH_LO_A && c <= scp_pkg::CH_LO_Z) begin
      return c - scp_pkg::CASE_DIFF;
    end
    return c;
  endfunction : to_upper

  function automatic logic is_hexl(input logic [7:0] c);
    return to_upper(c) >= scp_pkg::CH_UP_A && to_upper(c) <= scp_pkg::CH_UP_F;
  endfunction : is_hexl

  // Folds one decimal or hex digit into the running value.
  function automatic logic [15:0] add_digit(input logic [15:0] acc,
                                            input logic hex,
                                            input logic [7:0] c);
    logic [15:0] nib;
    logic [31:0] prod;
    nib  = {8'h00, is_digit(c) ? c - scp_pkg::CH_DIG0
                               : to_upper(c) - scp_pkg::HEX_AOFS};
    prod = acc * (hex ? scp_pkg::BASE_HEX : scp_pkg::BASE_DEC);
    return prod[15:0] + nib;
  endfunction : add_digit

  // Maps the letter after a backslash to its code; others pass through.
  function automatic logic [7:0] esc_map(input logic [7:0] c);
    case (c)
      scp_pkg::ESC_A: return scp_pkg::CH_BEL;
      scp_pkg::ESC_B: return scp_pkg::CH_BS;
      scp_pkg::ESC_F: return scp_pkg::CH_FF;
      scp_pkg::ESC_N: return scp_pkg::CH_LF;
      scp_pkg::ESC_R: return scp_pkg::CH_CR;
      scp_pkg::ESC_T: return scp_pkg::CH_TAB;
      scp_pkg::ESC_V: return scp_pkg::CH_VT;
      default:        return c;
    endcase
  endfunction : esc_map

  scp_line_buf u_line_buf (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (lb_clr),
    .pop_i  (lb_pop),
    .push_i (lb_push),
    .data_i (ch),
    .idx_i  (r_reg.idx),
    .cnt_o  (lb_cnt),
    .rd_o   (lb_rd)
  );

  // Replay bytes and host bytes share one editing path.
  assign ch = (r_reg.st == scp_pkg::ST_FEED) ? cfg_rdata_i : in_char_i;

  // Next-state logic for the whole controller.
  always_comb begin
    logic               take;
    logic               e_vld;
    logic               first;
    logic               done;
    scp_pkg::scp_kind_e e_kind;
    logic [15:0]        e_data;
    scp_pkg::scp_line_e lk_cur;
    take   = 1'b0;
    e_vld  = 1'b0;
    first  = 1'b0;
    done   = 1'b0;
    e_kind = scp_pkg::EK_NUM;
    e_data = '0;
    lk_cur = r_reg.lk;
    r_next = r_reg;
    lb_clr  = 1'b0;
    lb_pop  = 1'b0;
    lb_push = 1'b0;
    r_next.elem_valid = 1'b0;
    r_next.exec       = 1'b0;
    r_next.cfg.rd     = 1'b0;
    r_next.cfg.wr     = 1'b0;
    case (r_reg.st)
      scp_pkg::ST_IDLE: begin
        take = in_valid_i & r_reg.ready;
      end
      // Fetch the start-up pointer, high byte first.
      scp_pkg::ST_RD_HI: begin
        r_next.cfg.rd   = 1'b1;
        r_next.cfg.addr = scp_pkg::CFG_PTR_HI;
        r_next.st       = scp_pkg::ST_RD_LO;
      end
      scp_pkg::ST_RD_LO: begin
        r_next.cfg.rd   = 1'b1;
        r_next.cfg.addr = scp_pkg::CFG_PTR_LO;
        r_next.st       = scp_pkg::ST_CAP_HI;
      end
      scp_pkg::ST_CAP_HI: begin
        r_next.ptr[15:8] = cfg_rdata_i;
        r_next.st        = scp_pkg::ST_CAP_LO;
      end
      scp_pkg::ST_CAP_LO: begin
        r_next.cfg.rd   = 1'b1;
        r_next.cfg.addr = {r_reg.ptr[15:8], cfg_rdata_i};
        r_next.ptr      = {r_reg.ptr[15:8], cfg_rdata_i} + 16'h0001;
        r_next.st       = scp_pkg::ST_WAIT_LEN;
      end
      scp_pkg::ST_WAIT_LEN: begin
        r_next.st = scp_pkg::ST_CAP_LEN;
      end
      // The length byte counts every replayed byte.
      scp_pkg::ST_CAP_LEN: begin
        r_next.rem = cfg_rdata_i;
        if (cfg_rdata_i == 8'h00) begin
          r_next.replay = 1'b0;
          r_next.st     = scp_pkg::ST_IDLE;
        end else begin
          r_next.cmd_state = 1'b1;
          r_next.st        = scp_pkg::ST_RD_CHR;
        end
      end
      scp_pkg::ST_RD_CHR: begin
        r_next.cfg.rd   = 1'b1;
        r_next.cfg.addr = r_reg.ptr;
        r_next.ptr      = r_reg.ptr + 16'h0001;
        r_next.rem      = r_reg.rem - 8'h01;
        r_next.st       = scp_pkg::ST_WAIT_CHR;
      end
      scp_pkg::ST_WAIT_CHR: begin
        r_next.st = scp_pkg::ST_FEED;
      end
      scp_pkg::ST_FEED: begin
        take = 1'b1;
        if (r_reg.rem != 8'h00) begin
          r_next.st = scp_pkg::ST_RD_CHR;
        end else begin
          r_next.st = scp_pkg::ST_IDLE;
        end
      end
      scp_pkg::ST_PARSE: begin
        if (r_reg.idx == lb_cnt) begin
          // End of line acts as a final delimiter.
          if (r_reg.tok != scp_pkg::TK_NONE) begin
            e_vld = 1'b1;
          end else begin
            done = 1'b1;
          end
          r_next.tok = scp_pkg::TK_NONE;
        end else begin
          r_next.idx = r_reg.idx + 7'h01;
          if (r_reg.cmt) begin
            r_next.cmt = 1'b1;
          end else if (r_reg.in_str) begin
            if (r_reg.esc) begin
              e_vld      = 1'b1;
              e_kind     = scp_pkg::EK_CHAR;
              e_data     = {8'h00, esc_map(lb_rd)};
              r_next.esc = 1'b0;
            end else if (lb_rd == scp_pkg::CH_BSL) begin
              r_next.esc = 1'b1;
            end else if (lb_rd == scp_pkg::CH_QUOTE) begin
              r_next.in_str = 1'b0;
            end else begin
              e_vld  = 1'b1;
              e_kind = scp_pkg::EK_CHAR;
              e_data = {8'h00, lb_rd};
            end
          end else if (lb_rd == scp_pkg::CH_SPACE
                       || lb_rd == scp_pkg::CH_TAB
                       || lb_rd == scp_pkg::CH_COMMA
                       || lb_rd == scp_pkg::CH_SEMI
                       || lb_rd == scp_pkg::CH_QUOTE
                       || lb_rd == scp_pkg::CH_DOLLAR) begin
            // Close any pending element at a separator.
            e_vld         = r_reg.tok != scp_pkg::TK_NONE;
            r_next.tok    = (lb_rd == scp_pkg::CH_DOLLAR) ? scp_pkg::TK_HEX
                                                          : scp_pkg::TK_NONE;
            r_next.acc    = '0;
            r_next.cmt    = lb_rd == scp_pkg::CH_SEMI;
            r_next.in_str = lb_rd == scp_pkg::CH_QUOTE;
          end else if (r_reg.tok == scp_pkg::TK_NAME) begin
            r_next.acc = {r_reg.acc[7:0], to_upper(lb_rd)};
          end else if (is_digit(lb_rd)
                       || (r_reg.tok == scp_pkg::TK_HEX && is_hexl(lb_rd))) begin
            r_next.acc = add_digit(r_reg.acc, r_reg.tok == scp_pkg::TK_HEX,
                                   lb_rd);
            if (r_reg.tok == scp_pkg::TK_NONE) begin
              r_next.tok = scp_pkg::TK_DEC;
            end
          end else begin
            r_next.tok = scp_pkg::TK_NAME;
            r_next.acc = {8'h00, to_upper(lb_rd)};
          end
        end
        if (e_vld && e_kind != scp_pkg::EK_CHAR) begin
          e_kind = (r_reg.tok == scp_pkg::TK_NAME) ? scp_pkg::EK_NAME
                                                   : scp_pkg::EK_NUM;
          e_data = r_reg.acc;
        end
      end
      default: begin
        r_next.st = scp_pkg::ST_IDLE;
      end
    endcase

    // Route an element by the kind of line its first element set.
    if (e_vld) begin
      first = r_reg.lk == scp_pkg::LK_NONE;
      if (first) begin
        if (e_kind == scp_pkg::EK_NAME && e_data == scp_pkg::CFG_CMD_NAME) begin
          lk_cur = scp_pkg::LK_CFG;
        end else if (e_kind != scp_pkg::EK_NAME && r_reg.wpos_ok) begin
          lk_cur = scp_pkg::LK_DATA;
        end else begin
          lk_cur = scp_pkg::LK_CMD;
        end
      end
      r_next.lk = lk_cur;
      if (lk_cur == scp_pkg::LK_CMD) begin
        r_next.elem_valid = 1'b1;
        r_next.elem       = '{first: first, kind: e_kind, data: e_data};
      end else if (!first && lk_cur == scp_pkg::LK_CFG && !r_reg.addr_seen) begin
        r_next.wpos      = e_data;
        r_next.wpos_ok   = 1'b1;
        r_next.addr_seen = 1'b1;
      end else if (!first || lk_cur == scp_pkg::LK_DATA) begin
        r_next.cfg.wr    = 1'b1;
        r_next.cfg.addr  = r_reg.wpos;
        r_next.cfg.wdata = e_data[7:0];
        r_next.wpos      = r_reg.wpos + 16'h0001;
      end
    end

    // Line finished: execute commands, then resume replay or idle.
    if (done) begin
      r_next.exec = r_reg.lk == scp_pkg::LK_CMD;
      lb_clr      = 1'b1;
      if (r_reg.replay && r_reg.rem != 8'h00) begin
        r_next.st = scp_pkg::ST_RD_CHR;
      end else if (r_reg.replay) begin
        r_next.replay    = 1'b0;
        r_next.cmd_state = 1'b0;
        r_next.st        = scp_pkg::ST_IDLE;
      end else begin
        r_next.st = scp_pkg::ST_IDLE;
      end
    end

    // Line editor for every accepted byte.
    if (take) begin
      r_next.prev_cr = ch == scp_pkg::CH_CR;
      if (ch == scp_pkg::CH_PREFIX) begin
        r_next.cmd_state = 1'b1;
        lb_clr           = 1'b1;
      end else if (ch == scp_pkg::CH_SUFFIX) begin
        r_next.cmd_state = 1'b0;
        r_next.wpos_ok   = 1'b0;
        lb_clr           = 1'b1;
      end else if (!r_reg.cmd_state) begin
        r_next.prev_cr = 1'b0;
      end else if (ch == scp_pkg::CH_CR
                   || (ch == scp_pkg::CH_LF && !r_reg.prev_cr)) begin
        // A LF right after CR is swallowed as part of one terminator.
        r_next.st        = scp_pkg::ST_PARSE;
        r_next.idx       = '0;
        r_next.tok       = scp_pkg::TK_NONE;
        r_next.acc       = '0;
        r_next.in_str    = 1'b0;
        r_next.esc       = 1'b0;
        r_next.cmt       = 1'b0;
        r_next.lk        = scp_pkg::LK_NONE;
        r_next.addr_seen = 1'b0;
      end else if (ch == scp_pkg::CH_ESC) begin
        lb_clr = 1'b1;
      end else if (ch == scp_pkg::CH_BS) begin
        lb_pop = 1'b1;
      end else if (ch != scp_pkg::CH_LF) begin
        lb_push = 1'b1;
      end
    end

    // A last replay byte that opens no parse ends the replay here; a final
    // terminator must keep command state until its own parse is done.
    if (r_reg.st == scp_pkg::ST_FEED && r_reg.rem == 8'h00
        && r_next.st == scp_pkg::ST_IDLE) begin
      r_next.replay    = 1'b0;
      r_next.cmd_state = 1'b0;
    end

    r_next.ready = r_next.st == scp_pkg::ST_IDLE;
    // Reset starts the start-up replay straight away.
    if (rst_i) begin
      r_next        = '0;
      r_next.st     = scp_pkg::ST_RD_HI;
      r_next.tok    = scp_pkg::TK_NONE;
      r_next.lk     = scp_pkg::LK_NONE;
      r_next.elem   = '{first: 1'b0, kind: scp_pkg::EK_NUM, data: 16'h0000};
      r_next.replay = 1'b1;
      lb_clr        = 1'b1;
      lb_pop        = 1'b0;
      lb_push       = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    r_reg <= r_next;
  end

  // All outputs come straight from the state register.
  assign in_ready_o   = r_reg.ready;
  assign cfg_rd_o     = r_reg.cfg.rd;
  assign cfg_wr_o     = r_reg.cfg.wr;
  assign cfg_addr_o   = r_reg.cfg.addr;
  assign cfg_wdata_o  = r_reg.cfg.wdata;
  assign cmd_state_o  = r_reg.cmd_state;
  assign elem_valid_o = r_reg.elem_valid;
  assign elem_o       = r_reg.elem;
  assign exec_o       = r_reg.exec;

endmodule : scp_parser

`default_nettype wire

// ==== testbench/scp_monitor.sv ====
// Checker of the parser's handshake, command state and start-up reads.
`timescale 1ns/1ps
`default_nettype none

module scp_monitor (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Watched ports.
  input  wire logic        in_valid_i,
  input  wire logic [7:0]  in_char_i,
  input  wire logic        in_ready_o,
  input  wire logic        cfg_rd_o,
  input  wire logic [15:0] cfg_addr_o,
  input  wire logic        cmd_state_o,
  input  wire logic        exec_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A byte counts only on an edge where both sides agree.
  logic take;
  assign take = in_valid_i & in_ready_o;

  a_term_busy: assert property (
    take && cmd_state_o && in_char_i == scp_pkg::CH_CR |=> !in_ready_o)
    else $error("Ready stayed high after a terminator.");
  a_parse_bound: assert property (
    take && cmd_state_o && in_char_i == scp_pkg::CH_CR
    |-> ##[1:400] in_ready_o)
    else $error("Line parse did not finish in time.");
  a_exec_late: assert property (
    exec_o |-> !$past(in_ready_o))
    else $error("Execute came while bytes were still accepted.");
  a_exec_pulse: assert property (
    exec_o |=> !exec_o)
    else $error("Execute lasted more than one cycle.");
  a_exec_cmd: assert property (
    exec_o |-> $past(cmd_state_o))
    else $error("Execute outside command state.");
  a_enter_cmd: assert property (
    take && !cmd_state_o && in_char_i == scp_pkg::CH_PREFIX
    |=> cmd_state_o)
    else $error("Prefix did not enter command state.");
  a_leave_cmd: assert property (
    take && cmd_state_o && in_char_i == scp_pkg::CH_SUFFIX
    |=> !cmd_state_o)
    else $error("Suffix did not leave command state.");
  a_esc_quiet: assert property (
    take && cmd_state_o && in_char_i == scp_pkg::CH_ESC |=> !exec_o [*2])
    else $error("Cancel led to an execute.");
  a_ptr_first: assert property (
    $fell(rst_i) |-> ##[0:3] (cfg_rd_o && cfg_addr_o == scp_pkg::CFG_PTR_HI))
    else $error("Start-up pointer high byte not read.");
  a_ptr_order: assert property (
    cfg_rd_o && cfg_addr_o == scp_pkg::CFG_PTR_HI
    |=> cfg_rd_o && cfg_addr_o == scp_pkg::CFG_PTR_LO)
    else $error("Pointer low byte did not follow the high byte.");
endmodule : scp_monitor

`default_nettype wire

// ==== testbench/scp_cfg_mem.sv ====
// Byte-wide configuration memory answering one cycle after each read.
`timescale 1ns/1ps
`default_nettype none

module scp_cfg_mem (
  // Clock.
  input  wire logic        clk_i,
  // Access port from the parser.
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [65536];

  // Start-up image: pointer to the string, length byte, "AB" and a CR.
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem[16'h0000] = 8'h01;
    mem[16'h0001] = 8'h00;
    mem[16'h0100] = 8'h03;
    mem[16'h0101] = 8'h41;
    mem[16'h0102] = 8'h42;
    mem[16'h0103] = 8'h0d;
    rdata_o = 8'h00;
  end

  // Idle cycles invert the data so a stale byte is never taken as fresh.
  always @(posedge clk_i) begin
    if (wr_i) mem[addr_i] <= wdata_i;
    rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
  end
endmodule : scp_cfg_mem

`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the serial command line parser.
`timescale 1ns/1ps
`default_nettype none

module tb;
  // Design-facing signals.
  logic               clk_i      = 1'b0;
  logic               rst_i      = 1'b1;
  logic               in_valid_i = 1'b0;
  logic [7:0]         in_char_i  = 8'h00;
  logic               in_ready_o;
  logic               cfg_rd_o;
  logic               cfg_wr_o;
  logic [15:0]        cfg_addr_o;
  logic [7:0]         cfg_wdata_o;
  logic [7:0]         cfg_rdata_i;
  logic               cmd_state_o;
  logic               elem_valid_o;
  scp_pkg::scp_elem_s elem_o;
  logic               exec_o;
  // Bench bookkeeping.
  logic [19:0]        got_q [$];
  logic [19:0]        exp_q [$];
  logic [7:0]         exec_count = 8'h00;
  int                 err_count  = 0;
  int                 num_checks = 0;

  scp_parser dut (.clk_i, .rst_i, .in_valid_i, .in_char_i, .in_ready_o,
    .cfg_rd_o, .cfg_wr_o, .cfg_addr_o, .cfg_wdata_o, .cfg_rdata_i,
    .cmd_state_o, .elem_valid_o, .elem_o, .exec_o);
  scp_cfg_mem u_mem (.clk_i, .rd_i(cfg_rd_o), .wr_i(cfg_wr_o),
    .addr_i(cfg_addr_o), .wdata_i(cfg_wdata_o), .rdata_o(cfg_rdata_i));

  // Free-running clock at 100 MHz.
  always #5 clk_i = ~clk_i;

  // Collect every element and execute strobe the parser hands out.
  always @(posedge clk_i) begin
    if (elem_valid_o === 1'b1) got_q.push_back(elem_o);
    if (exec_o === 1'b1) exec_count <= exec_count + 8'h01;
  end

  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  // Element list and execute count since the last clear against expectation.
  task automatic chk_line(input logic [7:0] n_exec);
    chk_byte(8'(got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) begin
      num_checks++;
      if (i >= got_q.size() || got_q[i] !== exp_q[i]) begin
        err_count++;
        $display("Error at %0t: got %h expected %h", $time,
          (i < got_q.size()) ? got_q[i] : 20'h0_0000, exp_q[i]);
      end
    end
    chk_byte(exec_count, n_exec);
  endtask : chk_line

  function automatic logic [19:0] el(input logic f, input logic [2:0] k,
                                     input logic [15:0] d);
    return {f, k, d};
  endfunction : el

  // Holds a byte up until the parser takes it; a hang ends the run.
  task automatic send(input logic [7:0] c);
    int n;
    in_valid_i <= 1'b1;
    in_char_i  <= c;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (in_ready_o !== 1'b1 && n < 600);
    if (n >= 600) begin
      err_count++;
      stop_test();
    end
  endtask : send

  task automatic put(input string s);
    foreach (s[i]) send(s[i]);
  endtask : put

  // Releases the stream and waits, bounded, until the parser is ready.
  task automatic done();
    int n;
    in_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (in_ready_o !== 1'b1 && n < 600);
    if (n >= 600) begin
      err_count++;
      stop_test();
    end
    repeat (3) @(posedge clk_i);
  endtask : done

  task automatic clr();
    got_q.delete();
    exp_q.delete();
    exec_count = 8'h00;
  endtask : clr

  task automatic t_replay();
    done();
    exp_q = '{el(1'b1, scp_pkg::EK_NAME, 16'h4142)};
    chk_line(8'h01);
  endtask : t_replay

  task automatic t_enter();
    clr();
    put("ZZ\r");
    done();
    chk_line(8'h00);
    send(scp_pkg::CH_PREFIX);
    done();
    chk_byte({7'h00, cmd_state_o}, 8'h01);
  endtask : t_enter

  task automatic t_split();
    clr();
    put("LI S1\r");
    done();
    exp_q = '{el(1'b1, scp_pkg::EK_NAME, 16'h4c49),
              el(1'b0, scp_pkg::EK_NAME, 16'h5331)};
    chk_line(8'h01);
    clr();
    put("AB\tCD,EF\n");
    done();
    exp_q = '{el(1'b1, scp_pkg::EK_NAME, 16'h4142),
              el(1'b0, scp_pkg::EK_NAME, 16'h4344),
              el(1'b0, scp_pkg::EK_NAME, 16'h4546)};
    chk_line(8'h01);
    clr();
    put("GH\r\n");
    done();
    exp_q = '{el(1'b1, scp_pkg::EK_NAME, 16'h4748)};
    chk_line(8'h01);
  endtask : t_split

  task automatic t_edit();
    clr();
    put("QQ\033RS\r");
    done();
    exp_q = '{el(1'b1, scp_pkg::EK_NAME, 16'h5253)};
    chk_line(8'h01);
    clr();
    put("AB\010C\r");
    done();
    exp_q = '{el(1'b1, scp_pkg::EK_NAME, 16'h4143)};
    chk_line(8'h01);
  endtask : t_edit

  task automatic t_forms();
    logic [7:0] ev [8] = '{8'h07, 8'h08, 8'h0c, 8'h0a, 8'h0d, 8'h09,
                           8'h0b, 8'h5c};
    clr();
    put("N1 ;X Y\r");
    done();
    exp_q = '{el(1'b1, scp_pkg::EK_NAME, 16'h4e31)};
    chk_line(8'h01);
    clr();
    put("NU 10 $A5\r");
    done();
    exp_q = '{el(1'b1, scp_pkg::EK_NAME, 16'h4e55),
              el(1'b0, scp_pkg::EK_NUM, 16'h000a),
              el(1'b0, scp_pkg::EK_NUM, 16'h00a5)};
    chk_line(8'h01);
    clr();
    put("ES \"\\a\\b\\f\\n\\r\\t\\v\\\\\"\r");
    done();
    exp_q = '{el(1'b1, scp_pkg::EK_NAME, 16'h4553)};
    foreach (ev[i]) exp_q.push_back(el(1'b0, scp_pkg::EK_CHAR, {8'h00, ev[i]}));
    chk_line(8'h01);
  endtask : t_forms

  task automatic t_cfg();
    clr();
    put("EE $0200 $12 $34\r");
    put("EE $0300\r");
    put("7 \"Z\"\r");
    done();
    chk_line(8'h00);
    chk_byte(u_mem.mem[16'h0200], 8'h12);
    chk_byte(u_mem.mem[16'h0201], 8'h34);
    chk_byte(u_mem.mem[16'h0300], 8'h07);
    chk_byte(u_mem.mem[16'h0301], 8'h5a);
  endtask : t_cfg

  task automatic t_long();
    clr();
    repeat (85) send(8'h41);
    put("\r");
    done();
    exp_q = '{el(1'b1, scp_pkg::EK_NAME, 16'h4141)};
    chk_line(8'h01);
  endtask : t_long

  task automatic t_leave();
    send(scp_pkg::CH_SUFFIX);
    done();
    chk_byte({7'h00, cmd_state_o}, 8'h00);
    clr();
    put("QQ\r");
    done();
    chk_line(8'h00);
  endtask : t_leave

  // Reset for twenty cycles, then the scenarios in order.
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_replay();
    t_enter();
    t_split();
    t_edit();
    t_forms();
    t_cfg();
    t_long();
    t_leave();
    stop_test();
  end
endmodule : tb

bind scp_parser scp_monitor u_mon (.clk_i, .rst_i, .in_valid_i, .in_char_i,
  .in_ready_o, .cfg_rd_o, .cfg_addr_o, .cmd_state_o, .exec_o);

`default_nettype wire
